// [design/pfs_top.sv]
`timescale 1ns/10ps
module pfs_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // control inputs
  input wire logic ENABLE,
  input wire logic SUPPLY_OK,
  input wire logic SOFTSTART_DONE,
  // comparators
  input wire logic TEMP_SENSE_LOW,
  input wire logic TEMP_SENSE_HIGH,
  input wire logic DIE_HOT,
  input wire logic DIE_COOL,
  input wire logic [1:0] OC_TRIP,
  input wire logic FAST_UNDERVOLTAGE_TRIP,
  input wire logic COMP_HIGH,
  input wire logic FEEDBACK_OVER,
  input wire logic [1:0] LOW_GATE_ONE_LEVEL,
  // pwm requests
  input wire logic [1:0] PWM_HIGH,
  input wire logic [1:0] PWM_LOW,
  // thermal alert open drain
  input wire logic THERMAL_ALERT_N_IN,
  output logic THERMAL_ALERT_N_OUT,
  output logic THERMAL_ALERT_N_OE_N,
  // gate drive
  output logic [1:0] HIGH_GATE,
  output logic [1:0] LOW_GATE,
  output logic [1:0] OC_LIMIT,
  output logic [1:0] OC_SELECT,
  output logic OC_SELECT_VALID,
  // status
  output logic FAULT_THERMAL,
  output logic FAULT_UNDERVOLTAGE,
  output logic FAULT_OVERVOLTAGE,
  output logic SOFTSTART_ACTIVE
);
  pfs_pkg::pfs_cmp_type cmp_raw;
  pfs_pkg::pfs_cmp_type cmp;
  logic [2:0] ctl_s;
  logic [1:0] lg1_s;
  logic en_s;
  logic sup_s;
  logic ss_done_s;
  logic en_d_r;
  logic sup_d_r;
  logic toggle;
  pfs_pkg::pfs_state_type st_r;
  pfs_pkg::pfs_state_type st_nxt;
  logic alert_r;
  logic tsd_r;
  logic fuv_r;
  logic suv_r;
  logic ov_r;
  logic fuv_done;
  logic suv_done;
  logic ov_done;
  logic [pfs_pkg::CNT_W-1:0] ocset_cnt_r;
  logic [1:0] ocsel_r;
  logic ocsel_valid_r;
  pfs_pkg::pfs_gate_type gate_r;
  pfs_pkg::pfs_gate_type gate_nxt;
  logic normal;
  logic [1:0] run_high;
  logic [1:0] run_low;

  // any latch that keeps the gates from normal switching
  function automatic logic stop_switching(
    input logic therm,
    input logic fast,
    input logic slow,
    input logic over
  );
    return therm || fast || slow || over;
  endfunction

  // comparator results gathered into one word
  assign cmp_raw = '{temp_low: TEMP_SENSE_LOW, temp_high: TEMP_SENSE_HIGH,
                     die_hot: DIE_HOT, die_cool: DIE_COOL,
                     oc_trip: OC_TRIP,
                     fast_uv: FAST_UNDERVOLTAGE_TRIP,
                     comp_high: COMP_HIGH, fb_over: FEEDBACK_OVER};

  pfs_sync #(.W($bits(pfs_pkg::pfs_cmp_type))) u_cmp_sync (
    .clk(CLK),
    .rst(RST),
    .d(cmp_raw),
    .q(cmp)
  );

  // control levels cross into the clock domain too
  pfs_sync #(.W(3)) u_ctl_sync (
    .clk(CLK),
    .rst(RST),
    .d({ENABLE, SUPPLY_OK, SOFTSTART_DONE}),
    .q(ctl_s)
  );

  pfs_sync #(.W(2)) u_lg1_sync (
    .clk(CLK),
    .rst(RST),
    .d(LOW_GATE_ONE_LEVEL),
    .q(lg1_s)
  );

  assign en_s = ctl_s[2];
  assign sup_s = ctl_s[1];
  assign ss_done_s = ctl_s[0];

  // supply or enable edge clears latched faults
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      en_d_r <= 1'b0;
      sup_d_r <= 1'b0;
    end
    else
    begin
      en_d_r <= en_s;
      sup_d_r <= sup_s;
    end
  end

  // one-cycle pulse on either edge of supply or enable
  assign toggle = (en_s != en_d_r) || (sup_s != sup_d_r);

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      pfs_pkg::ST_STANDBY:
        if (en_s && sup_s && ocsel_valid_r)
          st_nxt = pfs_pkg::ST_SOFTSTART;
      pfs_pkg::ST_SOFTSTART:
        if (!en_s || !sup_s)
          st_nxt = pfs_pkg::ST_STANDBY;
        else if (stop_switching(tsd_r, 1'b0, suv_r, ov_r))
          st_nxt = pfs_pkg::ST_FAULT;
        else if (ss_done_s)
          st_nxt = pfs_pkg::ST_RUN;
      pfs_pkg::ST_RUN:
        if (!en_s || !sup_s)
          st_nxt = pfs_pkg::ST_STANDBY;
        else if (stop_switching(tsd_r, fuv_r, suv_r, ov_r))
          st_nxt = pfs_pkg::ST_FAULT;
      // leave only once every latch has cleared
      pfs_pkg::ST_FAULT:
        if (!stop_switching(tsd_r, fuv_r, suv_r, ov_r))
          st_nxt = pfs_pkg::ST_STANDBY;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      st_r <= pfs_pkg::ST_STANDBY;
    else
      st_r <= st_nxt;
  end

  // soft start and run both count as normal operation
  assign normal = (st_r == pfs_pkg::ST_SOFTSTART) || (st_r == pfs_pkg::ST_RUN);

  // thermal alert with hysteresis, off while enable is low
  always_ff @(posedge CLK)
  begin
    if (RST || !en_s)
      alert_r <= 1'b0;
    else if (cmp.temp_low)
      alert_r <= 1'b1;
    else if (cmp.temp_high)
      alert_r <= 1'b0;
  end

  // thermal shutdown latch
  always_ff @(posedge CLK)
  begin
    if (RST)
      tsd_r <= 1'b0;
    else if (cmp.die_hot)
      tsd_r <= 1'b1;
    else if (toggle && cmp.die_cool)
      tsd_r <= 1'b0;
  end

  // fast undervoltage armed only in the run state
  pfs_qual #(.CYC(pfs_pkg::FUV_CYC)) u_fuv_q (
    .clk(CLK),
    .rst(RST),
    .cond(cmp.fast_uv && st_r == pfs_pkg::ST_RUN),
    .done(fuv_done)
  );

  pfs_qual #(.CYC(pfs_pkg::SUV_CYC)) u_suv_q (
    .clk(CLK),
    .rst(RST),
    .cond(cmp.comp_high && normal),
    .done(suv_done)
  );

  pfs_qual #(.CYC(pfs_pkg::OV_CYC)) u_ov_q (
    .clk(CLK),
    .rst(RST),
    .cond(cmp.fb_over && normal),
    .done(ov_done)
  );

  // latched voltage faults, a new trip wins over the clear
  always_ff @(posedge CLK)
  begin
    if (RST)
      fuv_r <= 1'b0;
    else if (fuv_done)
      fuv_r <= 1'b1;
    else if (toggle)
      fuv_r <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      suv_r <= 1'b0;
    else if (suv_done)
      suv_r <= 1'b1;
    else if (toggle)
      suv_r <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      ov_r <= 1'b0;
    else if (ov_done)
      ov_r <= 1'b1;
    else if (toggle)
      ov_r <= 1'b0;
  end

  // over-current threshold detection after settling
  always_ff @(posedge CLK)
  begin
    if (RST || !en_s)
    begin
      ocset_cnt_r <= '0;
      ocsel_r <= pfs_pkg::OCSEL_RST;
      ocsel_valid_r <= 1'b0;
    end
    else if (!ocsel_valid_r)
    begin
      if (ocset_cnt_r == pfs_pkg::CNT_W'(pfs_pkg::OCSET_CYC))
      begin
        ocsel_r <= lg1_s;
        ocsel_valid_r <= 1'b1;
      end
      else
        ocset_cnt_r <= ocset_cnt_r + 1'b1;
    end
  end

  // per-phase switching; a tripped phase loses its high side
  for (genvar ph = 0; ph < 2; ph++)
  begin : g_phase
    assign run_high[ph] = PWM_HIGH[ph] && !cmp.oc_trip[ph];
    assign run_low[ph] = PWM_LOW[ph] && !PWM_HIGH[ph];
  end

  always_comb
  begin
    gate_nxt.high_on = '0;
    gate_nxt.low_on = '0;
    if (ov_r)
      gate_nxt.low_on = 2'h3;
    else if (stop_switching(tsd_r, fuv_r, suv_r, 1'b0) || !normal)
      gate_nxt.low_on = 2'h0;
    else
    begin
      gate_nxt.high_on = run_high;
      gate_nxt.low_on = run_low;
    end
  end

  // gates leave a flop so the pins cannot glitch
  always_ff @(posedge CLK)
  begin
    if (RST)
      gate_r <= '0;
    else
      gate_r <= gate_nxt;
  end

  assign HIGH_GATE = gate_r.high_on;
  assign LOW_GATE = gate_r.low_on;
  // open drain: pull low only while the alert stands
  assign THERMAL_ALERT_N_OUT = 1'b0;
  assign THERMAL_ALERT_N_OE_N = ~alert_r;
  assign OC_LIMIT = cmp.oc_trip;
  assign OC_SELECT = ocsel_r;
  assign OC_SELECT_VALID = ocsel_valid_r;
  assign FAULT_THERMAL = tsd_r;
  assign FAULT_UNDERVOLTAGE = fuv_r | suv_r;
  assign FAULT_OVERVOLTAGE = ov_r;
  assign SOFTSTART_ACTIVE = (st_r == pfs_pkg::ST_SOFTSTART);
endmodule

// [design/pfs_pkg.sv]
// Function
// - alert only while enabled, released when enable drops
// - sense below low threshold asserts alert
// - release only above higher threshold, hysteresis
// - die overtemperature enters shutdown, stops switching
// - shutdown cleared by supply/enable only when cool
// - over-current per phase restricts switching
// - threshold chosen from settled low-gate resistor
// - feedback low over 2 us latches gates off
// - fast undervoltage ignored during soft start
// - compensation high for 50 us latches off
// - latched faults held until supply/enable change
// - feedback high latches low gates on
package pfs_pkg;
  localparam int CLK_MHZ = 40;
  localparam int FUV_TIME_NS = 2000;
  localparam int OV_TIME_NS = 2000;
  localparam int SUV_TIME_US = 50;
  localparam int OCSET_TIME_US = 300;
  localparam int FUV_CYC = FUV_TIME_NS * CLK_MHZ / 1000 + 1;
  localparam int OV_CYC = OV_TIME_NS * CLK_MHZ / 1000 + 1;
  localparam int SUV_CYC = SUV_TIME_US * CLK_MHZ;
  localparam int OCSET_CYC = OCSET_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;
  localparam logic [1:0] OCSEL_RST = 2'h0;

  typedef struct packed {
    logic temp_low;
    logic temp_high;
    logic die_hot;
    logic die_cool;
    logic [1:0] oc_trip;
    logic fast_uv;
    logic comp_high;
    logic fb_over;
  } pfs_cmp_type;

  typedef struct packed {
    logic [1:0] high_on;
    logic [1:0] low_on;
  } pfs_gate_type;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_SOFTSTART = 2'b01,
    ST_RUN = 2'b10,
    ST_FAULT = 2'b11
  } pfs_state_type;
endpackage

// [design/pfs_sync.sv]
`timescale 1ns/10ps
module pfs_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else if (s2_r == s3_r)
      q <= s3_r;
  end
endmodule

// [design/pfs_qual.sv]
`timescale 1ns/10ps
module pfs_qual #(
  parameter int CYC = 1
) (
  // clock
  input wire logic clk,
  input wire logic rst,
  // condition
  input wire logic cond,
  output logic done
);
  logic [pfs_pkg::CNT_W-1:0] cnt_r;

  // counter restarts whenever the condition drops
  always_ff @(posedge clk)
  begin
    if (rst || !cond)
      cnt_r <= '0;
    else if (cnt_r != pfs_pkg::CNT_W'(CYC))
      cnt_r <= cnt_r + 1'b1;
  end

  assign done = cond && (cnt_r == pfs_pkg::CNT_W'(CYC));
endmodule

// [verif/pfs_assertions.sv]
`timescale 1ns/10ps
module pfs_assertions (
  // clock
  input wire logic CLK,
  input wire logic RST,
  // inputs
  input wire logic ENABLE,
  input wire logic SUPPLY_OK,
  input wire logic TEMP_SENSE_LOW,
  input wire logic TEMP_SENSE_HIGH,
  input wire logic FEEDBACK_OVER,
  // outputs
  input wire logic THERMAL_ALERT_N_OE_N,
  input wire logic [1:0] HIGH_GATE,
  input wire logic [1:0] LOW_GATE,
  input wire logic FAULT_THERMAL,
  input wire logic FAULT_UNDERVOLTAGE,
  input wire logic FAULT_OVERVOLTAGE
);
  logic [7:0] ov_cnt_r;
  logic [3:0] quiet_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // length of the current overvoltage run
  always_ff @(posedge CLK)
  begin
    if (RST || !FEEDBACK_OVER)
      ov_cnt_r <= 8'h00;
    else if (ov_cnt_r != 8'hff)
      ov_cnt_r <= ov_cnt_r + 8'h01;
  end
  // cycles since enable or supply last moved
  always_ff @(posedge CLK)
  begin
    if (RST || $changed(ENABLE) || $changed(SUPPLY_OK))
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hf)
      quiet_r <= quiet_r + 4'h1;
  end
  a_alert_standby: assert property
    (!ENABLE [*8] |-> THERMAL_ALERT_N_OE_N) else $error("alert in standby");
  a_alert_set: assert property
    ((TEMP_SENSE_LOW && ENABLE) [*8] |-> !THERMAL_ALERT_N_OE_N)
    else $error("alert missing");
  a_alert_hyst: assert property
    ((!THERMAL_ALERT_N_OE_N && !TEMP_SENSE_HIGH && ENABLE) [*8]
    |=> !THERMAL_ALERT_N_OE_N) else $error("alert released early");
  a_therm_gates: assert property
    (FAULT_THERMAL |=> HIGH_GATE == 2'h0) else $error("switching in shutdown");
  a_uv_gates: assert property
    (FAULT_UNDERVOLTAGE && !FAULT_OVERVOLTAGE
    |=> {HIGH_GATE, LOW_GATE} == 4'h0)
    else $error("gates on after undervoltage");
  a_ov_gates: assert property
    (FAULT_OVERVOLTAGE |=> LOW_GATE == 2'h3 && HIGH_GATE == 2'h0)
    else $error("wrong overvoltage gates");
  a_ov_qualify: assert property
    ($rose(FAULT_OVERVOLTAGE) |-> ov_cnt_r >= 8'h51) else $error("early ov");
  a_fault_hold: assert property
    (quiet_r > 4'h8
    |=> !$fell(FAULT_UNDERVOLTAGE) && !$fell(FAULT_OVERVOLTAGE))
    else $error("fault cleared");
  c_ov: cover property ($rose(FAULT_OVERVOLTAGE));
  c_uv: cover property ($rose(FAULT_UNDERVOLTAGE));
  c_alert: cover property ($fell(THERMAL_ALERT_N_OE_N));
  c_both: cover property (FAULT_UNDERVOLTAGE && FAULT_OVERVOLTAGE);
endmodule

bind pfs_top pfs_assertions u_chk (.CLK(CLK), .RST(RST), .ENABLE(ENABLE),
  .SUPPLY_OK(SUPPLY_OK), .TEMP_SENSE_LOW(TEMP_SENSE_LOW),
  .TEMP_SENSE_HIGH(TEMP_SENSE_HIGH), .FEEDBACK_OVER(FEEDBACK_OVER),
  .THERMAL_ALERT_N_OE_N(THERMAL_ALERT_N_OE_N), .HIGH_GATE(HIGH_GATE),
  .LOW_GATE(LOW_GATE), .FAULT_THERMAL(FAULT_THERMAL),
  .FAULT_UNDERVOLTAGE(FAULT_UNDERVOLTAGE),
  .FAULT_OVERVOLTAGE(FAULT_OVERVOLTAGE));

// [verif/pfs_stage.sv]
`timescale 1ns/10ps
module pfs_stage (
  // feedback level: 0 normal, 1 low, 2 high
  input wire logic [1:0] fb_level,
  // alert pin
  input wire logic alert_n_out,
  input wire logic alert_n_oe_n,
  output logic alert_n,
  // comparators
  output logic fast_uv,
  output logic fb_over
);
  // pull-up holds the released line high
  assign alert_n = alert_n_oe_n ? 1'b1 : alert_n_out;
  assign fast_uv = fb_level == 2'h1;
  assign fb_over = fb_level == 2'h2;
endmodule

// [verif/protection_fault_supervisor_bench.sv]
`timescale 1ns/10ps
module protection_fault_supervisor_bench;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, sok = 1'b0, ssd = 1'b0;
  logic tl = 1'b0, th = 1'b1, hot = 1'b0, cool = 1'b1, comp = 1'b0;
  logic [1:0] oc = 2'h0, lgl = 2'h0, ph = 2'h0, pl = 2'h0, fbl = 2'h0;
  logic fuv, fbo, al_n, al_out, al_oe_n, vld, f_th, f_uv, f_ov, ss;
  logic [1:0] hg, lg, ocl, osel;
  int n_errors = 0, comparisons = 0;
  pfs_top uut (.CLK(clk), .RST(rst), .ENABLE(en), .SUPPLY_OK(sok),
    .SOFTSTART_DONE(ssd), .TEMP_SENSE_LOW(tl), .TEMP_SENSE_HIGH(th),
    .DIE_HOT(hot), .DIE_COOL(cool), .OC_TRIP(oc),
    .FAST_UNDERVOLTAGE_TRIP(fuv), .COMP_HIGH(comp), .FEEDBACK_OVER(fbo),
    .LOW_GATE_ONE_LEVEL(lgl), .PWM_HIGH(ph), .PWM_LOW(pl),
    .THERMAL_ALERT_N_IN(al_n), .THERMAL_ALERT_N_OUT(al_out),
    .THERMAL_ALERT_N_OE_N(al_oe_n), .HIGH_GATE(hg), .LOW_GATE(lg),
    .OC_LIMIT(ocl), .OC_SELECT(osel), .OC_SELECT_VALID(vld),
    .FAULT_THERMAL(f_th), .FAULT_UNDERVOLTAGE(f_uv),
    .FAULT_OVERVOLTAGE(f_ov), .SOFTSTART_ACTIVE(ss));
  pfs_stage stage (.fb_level(fbl), .alert_n_out(al_out),
    .alert_n_oe_n(al_oe_n), .alert_n(al_n), .fast_uv(fuv), .fb_over(fbo));
  initial
    forever #12.5 clk = ~clk;
  task tally_and_finish;
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t saw %h want %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task waitfor(input bit run);
    int i;
    i = 0;
    while ((run ? ss !== 1'b0 : vld !== 1'b1) && i < 13000)
    begin
      @(posedge clk);
      i++;
    end
    if (i == 13000)
    begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  task off;
    en <= 1'b0;
    ssd <= 1'b0;
    cyc(20);
  endtask
  task run_up;
    en <= 1'b1;
    waitfor(0);
    cyc(8);
    ssd <= 1'b1;
    cyc(8);
    waitfor(1);
  endtask
  function logic [3:0] gates_for(input logic ov);
    return ov ? 4'h3 : 4'h0;
  endfunction
  initial
  begin
    void'($urandom(32'he80b025c));
    cyc(12);
    rst <= 1'b0;
    sok <= 1'b1;
    tl <= 1'b1;
    th <= 1'b0;
    lgl <= 2'($urandom);
    cyc(20);
    chk({3'h0, al_n}, 4'h1);
    run_up;
    chk({2'h0, osel}, {2'h0, lgl});
    chk({3'h0, al_n}, 4'h0);
    tl <= 1'b0;
    cyc(20);
    chk({3'h0, al_n}, 4'h0);
    th <= 1'b1;
    cyc(20);
    chk({3'h0, al_n}, 4'h1);
    repeat (8)
    begin
      oc <= 2'($urandom);
      ph <= 2'($urandom);
      pl <= 2'($urandom);
      cyc(8);
      chk({2'h0, ocl}, {2'h0, oc});
      chk({2'h0, hg}, {2'h0, ph & ~oc});
    end
    oc <= 2'h0;
    fbl <= 2'h2;
    cyc(60);
    fbl <= 2'h0;
    cyc(10);
    chk({3'h0, f_ov}, 4'h0);
    fbl <= 2'h2;
    cyc(100);
    fbl <= 2'h0;
    cyc(30);
    chk({hg, lg}, gates_for(1'b1));
    chk({2'h0, f_ov, f_uv}, 4'h2);
    off;
    chk({3'h0, f_ov}, 4'h0);
    en <= 1'b1;
    waitfor(0);
    cyc(8);
    fbl <= 2'h1;
    cyc(100);
    chk({3'h0, f_uv}, 4'h0);
    chk({3'h0, ss}, 4'h1);
    fbl <= 2'h0;
    ssd <= 1'b1;
    cyc(8);
    waitfor(1);
    fbl <= 2'h1;
    cyc(100);
    chk({2'h0, f_ov, f_uv}, 4'h1);
    chk({hg, lg}, gates_for(1'b0));
    fbl <= 2'h0;
    off;
    run_up;
    comp <= 1'b1;
    cyc(1919);
    fbl <= 2'h2;
    cyc(61);
    chk({3'h0, f_uv}, 4'h0);
    cyc(40);
    chk({3'h0, f_uv}, 4'h1);
    chk({2'h0, f_ov, f_uv}, 4'h3);
    chk({hg, lg}, gates_for(1'b1));
    comp <= 1'b0;
    fbl <= 2'h0;
    off;
    run_up;
    hot <= 1'b1;
    cool <= 1'b0;
    cyc(10);
    hot <= 1'b0;
    chk({3'h0, f_th}, 4'h1);
    chk({2'h0, hg}, 4'h0);
    off;
    en <= 1'b1;
    cyc(20);
    chk({3'h0, f_th}, 4'h1);
    cool <= 1'b1;
    sok <= 1'b0;
    cyc(20);
    sok <= 1'b1;
    cyc(20);
    chk({3'h0, f_th}, 4'h0);
    tally_and_finish;
  end
endmodule
